/* design/cmi_pkg.sv */
// Constants and types shared by the message buffer identifier block.
// Assumes a single 40 MHz module clock and byte-wide register access.
package cmi_pkg;

  // ----------------------------------------------------------------
  // Register map
  // ----------------------------------------------------------------
  localparam logic [3:0] TX_ID_BASE_OFS = 4'h0;
  localparam logic [3:0] RX_ID_BASE_OFS = 4'h4;
  localparam logic [3:0] STATUS_OFS     = 4'h8;

  localparam int STS_TX_ACTIVE_BIT = 0;
  localparam int STS_RX_VALID_BIT  = 1;
  localparam int STS_ARB_LOST_BIT  = 2;
  localparam int STS_BIT_ERR_BIT   = 3;

  localparam logic [7:0] RDATA_RESET  = 8'h00;
  localparam logic [3:0] STATUS_RESET = 4'h0;

  // ----------------------------------------------------------------
  // Identifier field layout
  // ----------------------------------------------------------------
  localparam int IDE_BIT     = 3;
  localparam int SRR_BIT     = 4;
  localparam int RTR_STD_BIT = 4;
  localparam int RTR_EXT_BIT = 0;

  localparam logic [5:0] STD_ARB_LEN = 6'h0D;
  localparam logic [5:0] EXT_ARB_LEN = 6'h20;
  localparam logic [5:0] CNT_ONE     = 6'h01;
  localparam logic [5:0] CNT_RESET   = 6'h00;

  localparam logic RECESSIVE = 1'b1;

  // ----------------------------------------------------------------
  // Types
  // ----------------------------------------------------------------
  typedef struct packed {
    logic [7:0] byte0;
    logic [7:0] byte1;
    logic [7:0] byte2;
    logic [7:0] byte3;
  } cmi_id_bytes_type;

  typedef enum logic {TX_IDLE, TX_SEND} cmi_tx_state_type;
  typedef enum logic {RX_IDLE, RX_COLLECT} cmi_rx_state_type;

endpackage

/* design/cmi_tx_pack.sv */
// Turns the four transmit identifier bytes into a left-aligned arbitration vector.
// Assumes the bytes are stable while the caller loads the vector.
`timescale 1ns/10ps
module cmi_tx_pack (
  input  cmi_pkg::cmi_id_bytes_type id_i,
  output logic [31:0]               arb_vec_o,
  output logic [5:0]                arb_len_o
);

  // ----------------------------------------------------------------
  // Packing
  // ----------------------------------------------------------------
  // Byte order already matches bus order, ID28 or ID10 first
  assign arb_vec_o = id_i; // R7
  // Standard uses only byte0 and the top five bits of byte1
  assign arb_len_o = id_i.byte1[cmi_pkg::IDE_BIT] ? cmi_pkg::EXT_ARB_LEN
                                                  : cmi_pkg::STD_ARB_LEN; // R13

endmodule

/* design/cmi_rx_unpack.sv */
// Places a received, left-aligned arbitration vector into the four identifier bytes.
// Assumes a standard vector has been shifted so that ID10 sits in bit 31.
`timescale 1ns/10ps
module cmi_rx_unpack (
  input  logic [31:0]               vec_i,
  input  logic                      ext_i,
  input  cmi_pkg::cmi_id_bytes_type cur_i,
  output cmi_pkg::cmi_id_bytes_type next_o
);

  // ----------------------------------------------------------------
  // Unpacking
  // ----------------------------------------------------------------
  cmi_pkg::cmi_id_bytes_type vec_bytes;

  assign vec_bytes = vec_i;
  // Extended: all 32 bits as sampled, SRR included
  // Standard: unused bits keep whatever they held
  assign next_o.byte0 = vec_bytes.byte0; // R3 R16
  assign next_o.byte1 = ext_i ? vec_bytes.byte1
                              : {vec_bytes.byte1[7:3], cur_i.byte1[2:0]}; // R4 R10 R16
  assign next_o.byte2 = ext_i ? vec_bytes.byte2 : cur_i.byte2; // R5
  assign next_o.byte3 = ext_i ? vec_bytes.byte3 : cur_i.byte3; // R6

endmodule

/* design/cmi_identifier_regs.sv */
// Identifier registers of one transmit and one receive message buffer, with the
// arbitration-field serializer and deserializer that use them.
// Assumes bit_tick_i and bus_bit_i come from bit timing logic on clk_i, so no
// synchroniser is needed; bus_bit_i is the sampled bus level at each tick.
//
// Notes on behaviour
// R1: Extended frame holds 29 ID bits, SRR, IDE and RTR in 32 bits.
// R2: Standard frame uses 13 bits: eleven ID bits, RTR and IDE.
// R3: Extended byte0 carries ID28 down to ID21, MSB in bit 7.
// R4: Extended byte1: ID20-18 in 7-5, SRR bit 4, IDE bit 3, ID17-15 in 2-0.
// R5: Extended byte2 carries ID14 down to ID7.
// R6: Extended byte3: ID6-0 in bits 7-1, RTR in bit 0.
// R7: Extended identifier is sent most significant bit first, ID28 leading.
// R8: Smallest identifier value wins; a dominant bus bit beats our recessive.
// R9: Software writes SRR as 1 in an extended transmit buffer.
// R10: Received SRR is stored exactly as sampled.
// R11: IDE zero means 11-bit standard, one means 29-bit extended.
// R12: Receive buffer IDE is set to the received frame's format.
// R13: Transmitter sends standard or extended per the stored IDE.
// R14: Received RTR is recorded for software.
// R15: Stored RTR is sent: zero data frame, one remote frame.
// R16: Standard: byte0 ID10-3; byte1 ID2-0 in 7-5, RTR 4, IDE 3.
// R17: Receive identifier bytes ignore CPU writes; only received frames load them.
// R18: Identifier bytes have no reset value; unused bits read undefined.
// R19: Standard transmit ignores byte1 low bits and bytes 2 and 3.
//
// The plain strobed port and the register offsets are this design's own decisions.
`timescale 1ns/10ps
module cmi_identifier_regs (
  input  logic       clk_i,
  input  logic       reset_i,
  input  logic [3:0] addr_i,
  input  logic [7:0] wdata_i,
  input  logic       wr_i,
  input  logic       rd_i,
  output logic [7:0] rdata_o,
  input  logic       tx_start_i,
  input  logic       rx_start_i,
  input  logic       bit_tick_i,
  input  logic       bus_bit_i,
  output logic       tx_bit_o,
  output logic       tx_active_o,
  output logic       tx_done_o,
  output logic       arb_lost_o,
  output logic       bit_err_o,
  output logic       rx_done_o,
  output logic       rx_ext_o
);

  // ----------------------------------------------------------------
  // Helpers
  // ----------------------------------------------------------------
  function automatic logic [7:0] pick_byte(input cmi_pkg::cmi_id_bytes_type b,
                                           input logic [1:0] idx);
    logic [7:0] r;
    r = b.byte0;
    case (idx)
      2'h1:    r = b.byte1;
      2'h2:    r = b.byte2;
      2'h3:    r = b.byte3;
      default: r = b.byte0;
    endcase
    return r;
  endfunction

  // ----------------------------------------------------------------
  // State
  // ----------------------------------------------------------------
  cmi_pkg::cmi_id_bytes_type tx_id_reg;
  cmi_pkg::cmi_id_bytes_type rx_id_reg;
  cmi_pkg::cmi_id_bytes_type rx_id_next;
  cmi_pkg::cmi_tx_state_type tx_state_reg;
  cmi_pkg::cmi_rx_state_type rx_state_reg;
  logic [31:0]               tx_sh_reg;
  logic [5:0]                tx_cnt_reg;
  logic [31:0]               rx_sh_reg;
  logic [5:0]                rx_cnt_reg;
  logic [3:0]                status_reg;
  logic [3:0]                status_next;
  logic [7:0]                rdata_reg;
  logic [7:0]                rdata_next;
  logic                      tx_bit_reg;
  logic                      tx_done_reg;
  logic                      arb_lost_reg;
  logic                      bit_err_reg;
  logic                      rx_done_reg;
  logic                      rx_ext_reg;

  // ----------------------------------------------------------------
  // Decode
  // ----------------------------------------------------------------
  logic        sel_tx;
  logic        sel_rx;
  logic        sel_sts;
  logic        tx_wr_en;
  logic        sts_wr;
  logic [31:0] arb_vec;
  logic [5:0]  arb_len;

  localparam logic [1:0] TX_ID_BASE_OFS_HI = cmi_pkg::TX_ID_BASE_OFS[3:2];
  localparam logic [1:0] RX_ID_BASE_OFS_HI = cmi_pkg::RX_ID_BASE_OFS[3:2];

  assign sel_tx  = (addr_i[3:2] == TX_ID_BASE_OFS_HI);
  assign sel_rx  = (addr_i[3:2] == RX_ID_BASE_OFS_HI);
  assign sel_sts = (addr_i == cmi_pkg::STATUS_OFS);
  // Buffer is owned by the transmitter while a frame is in flight
  assign tx_wr_en = wr_i & sel_tx & (tx_state_reg == cmi_pkg::TX_IDLE);
  assign sts_wr   = wr_i & sel_sts;

  // ----------------------------------------------------------------
  // Transmit path
  // ----------------------------------------------------------------
  logic tick_tx;
  logic lost_now;
  logic err_now;
  logic last_tx;
  logic tx_load;
  logic tx_stop;

  cmi_tx_pack u_pack (
    .id_i      (tx_id_reg),
    .arb_vec_o (arb_vec),
    .arb_len_o (arb_len)
  );

  assign tx_load  = (tx_state_reg == cmi_pkg::TX_IDLE) & tx_start_i;
  assign tick_tx  = (tx_state_reg == cmi_pkg::TX_SEND) & bit_tick_i;
  // Recessive sent but dominant seen: a smaller identifier is on the bus
  assign lost_now = tick_tx & tx_bit_reg & ~bus_bit_i; // R8
  assign err_now  = tick_tx & ~tx_bit_reg & bus_bit_i;
  assign last_tx  = tick_tx & (tx_cnt_reg == cmi_pkg::CNT_ONE);
  assign tx_stop  = lost_now | err_now | last_tx;

  always_ff @(posedge clk_i or posedge reset_i) begin
    if (reset_i) begin
      tx_state_reg <= cmi_pkg::TX_IDLE;
      tx_sh_reg    <= {32{cmi_pkg::RECESSIVE}};
      tx_cnt_reg   <= cmi_pkg::CNT_RESET;
      tx_bit_reg   <= cmi_pkg::RECESSIVE;
    end else begin
      case (tx_state_reg)
        cmi_pkg::TX_IDLE: begin
          if (tx_load) begin
            tx_state_reg <= cmi_pkg::TX_SEND;
            tx_sh_reg    <= arb_vec; // R1 R2 R19
            tx_cnt_reg   <= arb_len; // R11 R13
            tx_bit_reg   <= arb_vec[31]; // R7
          end
        end
        default: begin
          if (tx_stop) begin
            tx_state_reg <= cmi_pkg::TX_IDLE;
            tx_bit_reg   <= cmi_pkg::RECESSIVE;
            tx_cnt_reg   <= cmi_pkg::CNT_RESET;
          end else if (tick_tx) begin
            // SRR and RTR go out as stored, RTR last in an extended frame
            tx_sh_reg  <= {tx_sh_reg[30:0], cmi_pkg::RECESSIVE}; // R9 R15
            tx_bit_reg <= tx_sh_reg[30]; // R7
            tx_cnt_reg <= tx_cnt_reg - cmi_pkg::CNT_ONE;
          end
        end
      endcase
    end
  end

  always_ff @(posedge clk_i or posedge reset_i) begin
    if (reset_i) begin
      tx_done_reg  <= 1'b0;
      arb_lost_reg <= 1'b0;
      bit_err_reg  <= 1'b0;
    end else begin
      tx_done_reg  <= last_tx & ~lost_now & ~err_now;
      arb_lost_reg <= lost_now; // R8
      bit_err_reg  <= err_now;
    end
  end

  // ----------------------------------------------------------------
  // Receive path
  // ----------------------------------------------------------------
  logic        tick_rx;
  logic [31:0] rx_vec_next;
  logic [5:0]  rx_cnt_next;
  logic        std_end;
  logic        ext_end;
  logic        rx_store;
  logic [31:0] rx_aligned;

  assign tick_rx     = (rx_state_reg == cmi_pkg::RX_COLLECT) & bit_tick_i;
  assign rx_vec_next = {rx_sh_reg[30:0], bus_bit_i};
  assign rx_cnt_next = rx_cnt_reg + cmi_pkg::CNT_ONE;
  // Thirteenth bit is IDE; dominant ends a standard identifier
  assign std_end  = tick_rx & (rx_cnt_next == cmi_pkg::STD_ARB_LEN) & ~bus_bit_i; // R11 R12
  assign ext_end  = tick_rx & (rx_cnt_next == cmi_pkg::EXT_ARB_LEN);
  assign rx_store = std_end | ext_end;
  assign rx_aligned = std_end ? {rx_vec_next[12:0], 19'h00000} : rx_vec_next;

  cmi_rx_unpack u_unpack (
    .vec_i  (rx_aligned),
    .ext_i  (ext_end),
    .cur_i  (rx_id_reg),
    .next_o (rx_id_next)
  );

  always_ff @(posedge clk_i or posedge reset_i) begin
    if (reset_i) begin
      rx_state_reg <= cmi_pkg::RX_IDLE;
      rx_sh_reg    <= {32{cmi_pkg::RECESSIVE}};
      rx_cnt_reg   <= cmi_pkg::CNT_RESET;
    end else begin
      case (rx_state_reg)
        cmi_pkg::RX_IDLE: begin
          if (rx_start_i) begin
            rx_state_reg <= cmi_pkg::RX_COLLECT;
            rx_cnt_reg   <= cmi_pkg::CNT_RESET;
          end
        end
        default: begin
          if (rx_start_i) begin
            rx_cnt_reg <= cmi_pkg::CNT_RESET;
          end else if (rx_store) begin
            rx_state_reg <= cmi_pkg::RX_IDLE;
            rx_cnt_reg   <= cmi_pkg::CNT_RESET;
          end else if (tick_rx) begin
            rx_sh_reg  <= rx_vec_next;
            rx_cnt_reg <= rx_cnt_next;
          end
        end
      endcase
    end
  end

  always_ff @(posedge clk_i or posedge reset_i) begin
    if (reset_i) begin
      rx_done_reg <= 1'b0;
      rx_ext_reg  <= 1'b0;
    end else begin
      rx_done_reg <= rx_store & ~rx_start_i;
      if (rx_store & ~rx_start_i) begin
        rx_ext_reg <= ext_end; // R12
      end
    end
  end

  // ----------------------------------------------------------------
  // Identifier storage
  // ----------------------------------------------------------------
  // Modelled as RAM: no reset, so contents start undefined
  always_ff @(posedge clk_i) begin
    if (tx_wr_en) begin
      case (addr_i[1:0])
        2'h0:    tx_id_reg.byte0 <= wdata_i; // R3 R16
        2'h1:    tx_id_reg.byte1 <= wdata_i; // R4 R16
        2'h2:    tx_id_reg.byte2 <= wdata_i; // R5
        default: tx_id_reg.byte3 <= wdata_i; // R6
      endcase
    end
  end // R18

  // CPU has no write path here
  always_ff @(posedge clk_i) begin
    if (rx_store & ~rx_start_i) begin
      rx_id_reg <= rx_id_next; // R10 R14 R17
    end
  end // R18

  // ----------------------------------------------------------------
  // Status and read port
  // ----------------------------------------------------------------
  logic rx_valid_clr;
  logic arb_lost_clr;
  logic bit_err_clr;

  assign rx_valid_clr = sts_wr & wdata_i[cmi_pkg::STS_RX_VALID_BIT];
  assign arb_lost_clr = sts_wr & wdata_i[cmi_pkg::STS_ARB_LOST_BIT];
  assign bit_err_clr  = sts_wr & wdata_i[cmi_pkg::STS_BIT_ERR_BIT];

  // A set in the same cycle as its clear wins
  assign status_next[cmi_pkg::STS_TX_ACTIVE_BIT] = (tx_state_reg == cmi_pkg::TX_SEND);
  assign status_next[cmi_pkg::STS_RX_VALID_BIT]  = (rx_store & ~rx_start_i) |
      (status_reg[cmi_pkg::STS_RX_VALID_BIT] & ~rx_valid_clr);
  assign status_next[cmi_pkg::STS_ARB_LOST_BIT]  = lost_now |
      (status_reg[cmi_pkg::STS_ARB_LOST_BIT] & ~arb_lost_clr);
  assign status_next[cmi_pkg::STS_BIT_ERR_BIT]   = err_now |
      (status_reg[cmi_pkg::STS_BIT_ERR_BIT] & ~bit_err_clr);

  assign rdata_next = ~rd_i   ? cmi_pkg::RDATA_RESET :
                      sel_tx  ? pick_byte(tx_id_reg, addr_i[1:0]) :
                      sel_rx  ? pick_byte(rx_id_reg, addr_i[1:0]) : // R18
                      sel_sts ? {4'h0, status_reg} :
                                cmi_pkg::RDATA_RESET;

  always_ff @(posedge clk_i or posedge reset_i) begin
    if (reset_i) begin
      status_reg <= cmi_pkg::STATUS_RESET;
      rdata_reg  <= cmi_pkg::RDATA_RESET;
    end else begin
      status_reg <= status_next;
      rdata_reg  <= rdata_next;
    end
  end

  // ----------------------------------------------------------------
  // Outputs
  // ----------------------------------------------------------------
  assign rdata_o     = rdata_reg;
  assign tx_bit_o    = tx_bit_reg;
  assign tx_active_o = status_reg[cmi_pkg::STS_TX_ACTIVE_BIT];
  assign tx_done_o   = tx_done_reg;
  assign arb_lost_o  = arb_lost_reg;
  assign bit_err_o   = bit_err_reg;
  assign rx_done_o   = rx_done_reg;
  assign rx_ext_o    = rx_ext_reg;

endmodule

/* test/cmi_identifier_regs_asserts.sv */
// Port-level checker for the identifier register block.
// Assumes one clock domain and the asynchronous active-high reset.
`timescale 1ns/10ps
module cmi_identifier_regs_chk (
  input wire logic       clk_i,
  input wire logic       reset_i,
  input wire logic [3:0] addr_i,
  input wire logic [7:0] wdata_i,
  input wire logic       wr_i,
  input wire logic       rd_i,
  input wire logic [7:0] rdata_o,
  input wire logic       tx_start_i,
  input wire logic       rx_start_i,
  input wire logic       bit_tick_i,
  input wire logic       bus_bit_i,
  input wire logic       tx_bit_o,
  input wire logic       tx_active_o,
  input wire logic       tx_done_o,
  input wire logic       arb_lost_o,
  input wire logic       bit_err_o,
  input wire logic       rx_done_o,
  input wire logic       rx_ext_o
);
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (reset_i);
  // ----------------------------------------------------------------
  // Sequences
  // ----------------------------------------------------------------
  sequence s_tx_go;
    tx_start_i && !tx_active_o && !$past(tx_start_i);
  endsequence
  sequence s_outvoted;
    $past(bit_tick_i && tx_bit_o && !bus_bit_i);
  endsequence
  // ----------------------------------------------------------------
  // Properties
  // ----------------------------------------------------------------
  a_tx_starts: assert property (s_tx_go |-> ##2 tx_active_o)
    else $error("idle start did not begin sending");
  a_lost_cause: assert property (arb_lost_o |-> s_outvoted)
    else $error("arbitration loss without recessive outvoted");
  a_err_cause: assert property (bit_err_o |-> $past(bit_tick_i && !tx_bit_o && bus_bit_i))
    else $error("bit error without dominant overridden");
  a_done_recessive: assert property (tx_done_o |-> $past(bit_tick_i) && tx_bit_o)
    else $error("done not after a tick or line not released");
  a_bit_holds: assert property (tx_active_o && $past(tx_active_o) && !$past(bit_tick_i)
    |-> $stable(tx_bit_o))
    else $error("sent bit changed between ticks");
  a_idle_recessive: assert property (!tx_active_o && !$past(tx_start_i) |-> tx_bit_o)
    else $error("idle transmitter not recessive");
  a_rx_on_tick: assert property (rx_done_o |-> $past(bit_tick_i))
    else $error("receive store not after a tick");
  a_std_ide: assert property (rx_done_o && !rx_ext_o |-> !$past(bus_bit_i))
    else $error("standard store with recessive format bit");
  a_ext_holds: assert property (!rx_done_o |-> $stable(rx_ext_o))
    else $error("format flag moved without a store");
  a_rd_window: assert property (rdata_o != 8'h00 |-> $past(rd_i))
    else $error("read data outside its cycle");
endmodule
bind cmi_identifier_regs cmi_identifier_regs_chk u_chk (.clk_i(clk_i), .reset_i(reset_i),
  .addr_i(addr_i), .wdata_i(wdata_i), .wr_i(wr_i), .rd_i(rd_i), .rdata_o(rdata_o),
  .tx_start_i(tx_start_i), .rx_start_i(rx_start_i), .bit_tick_i(bit_tick_i),
  .bus_bit_i(bus_bit_i), .tx_bit_o(tx_bit_o), .tx_active_o(tx_active_o),
  .tx_done_o(tx_done_o), .arb_lost_o(arb_lost_o), .bit_err_o(bit_err_o),
  .rx_done_o(rx_done_o), .rx_ext_o(rx_ext_o));

/* test/cmi_bus_node.sv */
// Behavioural second bus node: bit timing, wired-AND bus, one frame at a time.
// Assumes the block's sent bit is registered on the same clock.
`timescale 1ns/10ps
module cmi_bus_node #(
  parameter int PER = 4
) (
  input  wire logic        clk_i,
  input  wire logic        reset_i,
  input  wire logic        send_i,
  input  wire logic [31:0] frame_i,
  input  wire logic        tx_bit_i,
  output logic             bit_tick_o,
  output logic             bus_bit_o,
  output logic             rx_start_o
);
  logic [31:0] sh_reg;
  int          cnt_reg;
  assign bit_tick_o = (cnt_reg == PER - 1);
  // Dominant zero wins on the shared line
  assign bus_bit_o  = tx_bit_i & sh_reg[31];
  always_ff @(posedge clk_i or posedge reset_i) begin
    if (reset_i) begin
      sh_reg     <= 32'hFFFFFFFF;
      cnt_reg    <= 0;
      rx_start_o <= 1'b0;
    end else begin
      rx_start_o <= send_i;
      cnt_reg    <= (send_i || bit_tick_o) ? 0 : cnt_reg + 1;
      if (send_i) begin
        sh_reg <= frame_i;
      end else if (bit_tick_o && sh_reg[31] && !bus_bit_o) begin
        sh_reg <= 32'hFFFFFFFF;
      end else if (bit_tick_o) begin
        sh_reg <= {sh_reg[30:0], 1'b1};
      end
    end
  end
endmodule

/* test/testbench.sv */
// Self-checking bench: register port, own transmissions, frames from a second node.
// Assumes the package register map and a four-cycle bit time.
`timescale 1ns/10ps
`define CHK(nm, e, g) begin tests_run++; if ((g) !== (e)) begin n_errors++; \
  $display("[ERR] %s expected %h seen %h", nm, e, g); end end
module testbench;
  typedef struct packed {logic [33:0] v; logic [33:0] m;} cmi_exp_type;
  logic        clk_i, reset_i, wr, rd, tx_start, send, rd_d, tick, bus, rx_start;
  logic        tx_bit, tx_act, tx_done, lost, berr, rx_done, rx_ext, go_d;
  logic [3:0]  addr;
  logic [7:0]  wdata, rdata;
  logic [31:0] frame, cap, id, t;
  int          n_errors = 0, tests_run = 0, k;
  cmi_exp_type q[$];
  cmi_identifier_regs dut (.clk_i(clk_i), .reset_i(reset_i), .addr_i(addr), .wdata_i(wdata),
    .wr_i(wr), .rd_i(rd), .rdata_o(rdata), .tx_start_i(tx_start), .rx_start_i(rx_start),
    .bit_tick_i(tick), .bus_bit_i(bus), .tx_bit_o(tx_bit), .tx_active_o(tx_act),
    .tx_done_o(tx_done), .arb_lost_o(lost), .bit_err_o(berr), .rx_done_o(rx_done),
    .rx_ext_o(rx_ext));
  cmi_bus_node #(.PER(4)) node (.clk_i(clk_i), .reset_i(reset_i), .send_i(send),
    .frame_i(frame), .tx_bit_i(tx_bit), .bit_tick_o(tick), .bus_bit_o(bus),
    .rx_start_o(rx_start));
  initial begin
    clk_i = 1'b0;
    forever #12.5 clk_i = ~clk_i;
  end
  task automatic finish_test;
    $display("errors %0d checks %0d", n_errors, tests_run);
    if (n_errors == 0 && tests_run > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask
  function automatic void chk_pop(string nm, logic [33:0] g);
    cmi_exp_type e;
    if (q.size() == 0) begin
      n_errors++;
      $display("[ERR] %s expected none seen %h", nm, g);
      return;
    end
    e = q.pop_front();
    `CHK(nm, e.v & e.m, g & e.m)
  endfunction
  // ----------------------------------------------------------------
  // Monitor: results are matched against the oldest note
  // ----------------------------------------------------------------
  always @(posedge clk_i) begin
    if (rd_d) chk_pop("rdata", {26'h0, rdata});
    if (tx_done | lost) chk_pop("tx_bits", {tx_done, lost, cap});
    // Status lags the state by a cycle, so the first cycle of sending is covered by go_d
    cap  <= tx_start ? 32'h0 : (tick && (tx_act || go_d)) ? {cap[30:0], tx_bit} : cap;
    go_d <= tx_start;
    rd_d <= rd;
  end
  task automatic wreg(input logic [3:0] a, input logic [7:0] d);
    @(posedge clk_i);
    addr  <= a;
    wdata <= d;
    wr    <= 1'b1;
    @(posedge clk_i);
    wr <= 1'b0;
  endtask
  task automatic rreg(input logic [3:0] a, input logic [7:0] e, input logic [7:0] m);
    q.push_back({{26'h0, e}, {26'h0, m}});
    @(posedge clk_i);
    addr <= a;
    rd   <= 1'b1;
    @(posedge clk_i);
    rd <= 1'b0;
  endtask
  task automatic go(input logic [31:0] f, input logic tx, input logic sn);
    @(posedge clk_i);
    frame    <= f;
    send     <= sn;
    tx_start <= tx;
    @(posedge clk_i);
    send     <= 1'b0;
    tx_start <= 1'b0;
  endtask
  task automatic wait_ev(input logic rx);
    int i;
    for (i = 0; i < 600; i++) begin
      @(posedge clk_i);
      if ((rx ? rx_done : (tx_done | lost | berr)) === 1'b1) break;
    end
    if (i == 600) begin
      n_errors++;
      $display("[ERR] completion expected 1 seen 0");
      finish_test();
    end
  endtask
  task automatic rx_case(input logic [31:0] f, input logic ext);
    int j;
    go(f, 1'b0, 1'b1);
    wait_ev(1'b1);
    `CHK("rx_ext", ext, rx_ext)
    wreg(cmi_pkg::RX_ID_BASE_OFS, ~f[31:24]);
    for (j = 0; j < 4; j++) rreg(cmi_pkg::RX_ID_BASE_OFS + 4'(j), f[31-8*j -: 8],
      (j == 0 || ext) ? 8'hFF : (j == 1) ? 8'hF8 : 8'h00);
  endtask
  task automatic tx_case(input logic [31:0] p, input logic [1:0] fl, input logic [33:0] m);
    int j;
    for (j = 0; j < 4; j++) wreg(cmi_pkg::TX_ID_BASE_OFS + 4'(j), t[31-8*j -: 8]);
    for (j = 0; j < 4; j++) rreg(cmi_pkg::TX_ID_BASE_OFS + 4'(j), t[31-8*j -: 8], 8'hFF);
    q.push_back({{fl, t[19] ? t : {19'h0, t[31:19]}}, m});
    go(p, 1'b1, p != 32'hFFFFFFFF);
    wait_ev(1'b0);
  endtask
  initial begin
    {reset_i, wr, rd, tx_start, send, rd_d, go_d, addr, wdata, cap} = {1'b1, 50'h0};
    frame = 32'hFFFFFFFF;
    k = $urandom(5207);
    repeat (3) @(posedge clk_i);
    reset_i <= 1'b0;
    rreg(cmi_pkg::STATUS_OFS, 8'h00, 8'hFF);
    rreg(4'hC, 8'h00, 8'hFF);
    $display("test register map done");
    for (k = 0; k < 3; k++) begin
      id = $urandom;
      rx_case({id[28:18], id[29], 1'b1, id[17:0], id[30]}, 1'b1);
      rx_case({id[10:0], id[31], 1'b0, 19'h7FFFF}, 1'b0);
      t = $urandom;
      t[20] = 1'b1;
      t[19] = 1'b1;
      tx_case(32'hFFFFFFFF, 2'b10, 34'h3FFFFFFFF);
      t[19] = 1'b0;
      tx_case(32'hFFFFFFFF, 2'b10, {2'b11, 19'h0, 13'h1FFF});
      t[31] = 1'b1;
      t[19] = 1'b1;
      tx_case({1'b0, t[30:0]}, 2'b01, 34'h300000000);
      t[31] = 1'b0;
      tx_case({1'b1, t[30:0]}, 2'b10, 34'h3FFFFFFFF);
      $display("test round %0d done", k);
    end
    repeat (4) @(posedge clk_i);
    finish_test();
  end
endmodule
